/* File: logic/ums_top.sv */
// modem line status and interrupt source enable block with apb slave
`timescale 1ns/10ps
module ums_top
  import ums_pkg::*;
(
  input  wire logic        pclk,          // 50 mhz bus clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cts_n,         // clear to send pin, active low
  input  wire logic [7:0]  general_pin_in,// general pin levels
  output logic             rts_n,         // request to send, active low
  output logic             dtr_n,         // data terminal ready on pin five
  input  wire logic        rx_err_lvl,    // receiver line error pending
  input  wire logic        rhr_lvl,       // receive holding data ready
  input  wire logic        thr_ready,     // transmit level at threshold
  input  wire logic        xoff_pulse,    // xoff character received
  input  wire logic        xoff_ack,      // xoff interrupt acknowledged
  input  wire logic        flow_ack,      // cts/rts interrupt acknowledged
  output logic             sleep_en,      // sleep mode request
  output logic             irq_n          // interrupt request, active low
);
  import ums_pkg::*;

  ums_state_t st_r;   // registered state
  ums_state_t st_nxt; // next state
  logic       cts_s;  // synchronised cts_n
  logic [7:0] pin_s;  // synchronised general pins

  // pins come from outside the clock domain
  // cts and all eight general pins share one synchroniser bank
  ums_sync #(.WIDTH(9)) ums_sync_i (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({cts_n, general_pin_in}),
    .sync_out ({cts_s, pin_s})
  );

  logic       modem_sel;  // general pins act as modem lines
  logic       loop_en;    // internal loopback
  logic       cts_eff;    // effective cts_n
  logic       dsr_eff;    // effective dsr_n
  logic       ri_eff;     // effective ri_n
  logic       cd_eff;     // effective cd_n
  logic       rts_eff;    // rts_n as driven
  logic [7:0] mls_val;    // assembled status byte
  logic [7:0] pls_val;    // assembled pin state byte
  logic       setup_ph;   // apb setup cycle
  logic       acc_ph;     // apb access cycle
  logic       wr_acc;     // write takes effect now
  logic       rd_mls;     // status read completes now
  logic       addr_ok;    // address is mapped for the access direction
  logic [3:0] ev;         // change events this cycle
  logic [7:0] src;        // raw interrupt sources by enable position

  // effective modem inputs
  always_comb
  begin
    modem_sel = st_r.pfc[UMS_PFC_MODEM];
    loop_en   = st_r.mlc[UMS_MLC_LOOP];
    rts_eff   = ~st_r.mlc[UMS_MLC_RTS];
    if (loop_en)
    begin
      cts_eff = ~st_r.mlc[UMS_MLC_RTS];
      dsr_eff = ~st_r.mlc[UMS_MLC_DTR];
    end
    else
    begin
      cts_eff = cts_s;
      // unselected pins look like inactive lines
      dsr_eff = modem_sel ? pin_s[UMS_PIN_DSR] : 1'b1;
    end
    ri_eff = modem_sel ? pin_s[UMS_PIN_RI] : 1'b1;
    cd_eff = modem_sel ? pin_s[UMS_PIN_CD] : 1'b1;
  end

  // status and pin state bytes
  always_comb
  begin
    mls_val = UMS_RST_BYTE;
    mls_val[UMS_MLS_CD]  = ~cd_eff;
    mls_val[UMS_MLS_RI]  = ~ri_eff;
    mls_val[UMS_MLS_DSR] = ~dsr_eff;
    mls_val[UMS_MLS_CTS] = ~cts_eff;
    mls_val[3:0] = st_r.delta;
    // modem pins hidden from pin state
    pls_val = modem_sel ? (pin_s & ~UMS_PLS_HIDE) : pin_s;
  end

  // apb decode; zero wait states
  // pready is tied high, so every access ends in its first access cycle
  always_comb
  begin
    setup_ph = psel & ~penable;
    acc_ph   = psel & penable;
    case (paddr)
      UMS_OFF_MLS, UMS_OFF_PLS: addr_ok = ~pwrite;
      UMS_OFF_ISE, UMS_OFF_EFC,
      UMS_OFF_PFC, UMS_OFF_MLC: addr_ok = 1'b1;
      default:                  addr_ok = 1'b0;
    endcase
    wr_acc = acc_ph & pwrite & addr_ok;
    rd_mls = acc_ph & ~pwrite & (paddr == UMS_OFF_MLS);
  end

  // change events and interrupt sources
  always_comb
  begin
    // any level change of cd, dsr, cts
    ev[UMS_MLS_DCD]  = cd_eff ^ st_r.cd_q;
    ev[UMS_MLS_DDSR] = dsr_eff ^ st_r.dsr_q;
    ev[UMS_MLS_DCTS] = cts_eff ^ st_r.cts_q;
    ev[UMS_MLS_TERI] = ri_eff & ~st_r.ri_q;
    src = UMS_RST_BYTE;
    src[UMS_ISE_RHR]   = rhr_lvl;
    src[UMS_ISE_THR]   = st_r.thr_pend;
    src[UMS_ISE_RXLS]  = rx_err_lvl;
    src[UMS_ISE_MODEM] = |st_r.delta;
    src[UMS_ISE_XOFF]  = st_r.xoff_pend;
    src[UMS_ISE_CTS]   = st_r.flow_pend & st_r.cts_q;
    src[UMS_ISE_RTS]   = st_r.flow_pend & st_r.rts_q;
  end

  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cts_q = cts_eff;
    st_nxt.dsr_q = dsr_eff;
    st_nxt.ri_q  = ri_eff;
    st_nxt.cd_q  = cd_eff;
    st_nxt.rts_q = rts_eff;
    st_nxt.thr_q = thr_ready;
    // clear only what was read, new events win
    st_nxt.delta = (rd_mls ? (st_r.delta & ~st_r.rdata[3:0]) : st_r.delta) | ev;
    if (thr_ready & ~st_r.thr_q)
      st_nxt.thr_pend = 1'b1;
    else if (!thr_ready)
      st_nxt.thr_pend = 1'b0;
    // xoff pending, set wins over acknowledge
    st_nxt.xoff_pend = xoff_pulse | (st_r.xoff_pend & ~xoff_ack);
    // one latch serves both lines; the enable bits choose which level qualifies it
    // cts or rts active to inactive
    st_nxt.flow_pend = (cts_eff & ~st_r.cts_q) | (rts_eff & ~st_r.rts_q)
                       | (st_r.flow_pend & ~flow_ack);
    if (wr_acc)
    begin
      case (paddr)
        UMS_OFF_ISE:
        begin
          if (st_r.efc[UMS_EFC_ENH])
            st_nxt.ise = pwdata[7:0];
          else
            st_nxt.ise = (st_r.ise & UMS_ISE_PROT) | (pwdata[7:0] & ~UMS_ISE_PROT);
        end
        UMS_OFF_EFC: st_nxt.efc = pwdata[7:0];
        UMS_OFF_PFC: st_nxt.pfc = pwdata[7:0];
        UMS_OFF_MLC:
        begin
          // protected control bits share the same write enable
          if (st_r.efc[UMS_EFC_ENH])
            st_nxt.mlc = pwdata[7:0];
          else
            st_nxt.mlc = (st_r.mlc & UMS_MLC_PROT) | (pwdata[7:0] & ~UMS_MLC_PROT);
        end
        default: st_nxt.mlc = st_r.mlc;
      endcase
    end
    // read data captured in setup, so it stands through the access cycle
    if (setup_ph & ~pwrite)
    begin
      case (paddr)
        UMS_OFF_MLS: st_nxt.rdata = {24'h00_0000, mls_val};
        UMS_OFF_ISE: st_nxt.rdata = {24'h00_0000, st_r.ise};
        UMS_OFF_EFC: st_nxt.rdata = {24'h00_0000, st_r.efc};
        UMS_OFF_PFC: st_nxt.rdata = {24'h00_0000, st_r.pfc};
        UMS_OFF_MLC: st_nxt.rdata = {24'h00_0000, st_r.mlc};
        UMS_OFF_PLS: st_nxt.rdata = {24'h00_0000, pls_val};
        default:     st_nxt.rdata = UMS_RST_WORD;
      endcase
    end
    st_nxt.irq = |(src & st_r.ise & ~(8'h01 << UMS_ISE_SLEEP));
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r       <= '0;
      // modem line edge detectors start at the idle high level, so reset gives no false edge
      st_r.cts_q <= 1'b1;
      st_r.dsr_q <= 1'b1;
      st_r.ri_q  <= 1'b1;
      st_r.cd_q  <= 1'b1;
      st_r.rts_q <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // outputs
  always_comb
  begin
    prdata   = st_r.rdata;
    pready   = 1'b1;
    pslverr  = acc_ph & ~addr_ok;
    // rts_n lags the control write by one cycle, unlike dtr_n which follows the written bit directly
    rts_n    = st_r.rts_q;
    dtr_n    = ~st_r.mlc[UMS_MLC_DTR];
    sleep_en = st_r.ise[UMS_ISE_SLEEP];
    irq_n    = ~st_r.irq;
  end

  // checks
  AST_CTS_INV: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph & ~pwrite & (paddr == UMS_OFF_MLS)) |=> (prdata[UMS_MLS_CTS] == ~$past(cts_eff)))
    else $error("cts status bit not inverted line");
  AST_CD_INV: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph & ~pwrite & (paddr == UMS_OFF_MLS) & modem_sel)
      |=> (prdata[UMS_MLS_CD] == ~$past(pin_s[UMS_PIN_CD])))
    else $error("cd status bit wrong");

  // remaining status levels, hidden pins, change flags and interrupt request
  AST_RI_INV: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph & ~pwrite & (paddr == UMS_OFF_MLS) & modem_sel)
      |=> (prdata[UMS_MLS_RI] == ~$past(pin_s[UMS_PIN_RI])))
    else $error("ri status bit wrong");
  AST_DSR_INV: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph & ~pwrite & (paddr == UMS_OFF_MLS) & modem_sel & ~loop_en)
      |=> (prdata[UMS_MLS_DSR] == ~$past(pin_s[UMS_PIN_DSR])))
    else $error("dsr status bit wrong");
  AST_PLS_HIDE: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph & ~pwrite & (paddr == UMS_OFF_PLS) & modem_sel)
      |=> ((prdata[7:0] & UMS_PLS_HIDE) == UMS_RST_BYTE))
    else $error("modem pins visible in pin state");
  AST_RI_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(ri_eff) & modem_sel) |=> st_r.delta[UMS_MLS_TERI])
    else $error("ri rising edge not latched");
  AST_RI_NOFALL: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(st_r.ri_q) & ~$past(st_r.delta[UMS_MLS_TERI])) |-> ~st_r.delta[UMS_MLS_TERI])
    else $error("ri falling edge latched");
  AST_DCTS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (cts_eff != st_r.cts_q) |=> st_r.delta[UMS_MLS_DCTS] [*1])
    else $error("cts change not latched");
  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_mls & (ev == 4'h0) & (st_r.rdata[3:0] == st_r.delta)) |=> (st_r.delta == 4'h0))
    else $error("status read did not clear flags");
  AST_NO_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_mls & ev[UMS_MLS_DDSR]) |=> st_r.delta[UMS_MLS_DDSR])
    else $error("change lost during status read");
  AST_IRQ_MODEM: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ise[UMS_ISE_MODEM] & (|st_r.delta)) |=> ~irq_n)
    else $error("modem change did not interrupt");
  AST_IRQ_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    ((st_r.ise & ~(8'h01 << UMS_ISE_SLEEP)) == 8'h00) |=> irq_n)
    else $error("interrupt with all sources disabled");

  // each enabled source reaches the request one cycle later
  AST_IRQ_RHR: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ise[UMS_ISE_RHR] & rhr_lvl) |=> ~irq_n)
    else $error("receive holding interrupt missing");
  AST_IRQ_RXLS: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ise[UMS_ISE_RXLS] & rx_err_lvl) |=> ~irq_n)
    else $error("line error interrupt missing");
  AST_IRQ_THR: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ise[UMS_ISE_THR] & st_r.thr_pend) |=> ~irq_n)
    else $error("transmit holding interrupt missing");
  AST_IRQ_XOFF: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ise[UMS_ISE_XOFF] & st_r.xoff_pend) |=> ~irq_n)
    else $error("xoff interrupt missing");
  AST_IRQ_FLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.flow_pend & ((st_r.ise[UMS_ISE_CTS] & st_r.cts_q)
      | (st_r.ise[UMS_ISE_RTS] & st_r.rts_q))) |=> ~irq_n)
    else $error("flow line interrupt missing");
  AST_ENH_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc & (paddr == UMS_OFF_ISE) & ~st_r.efc[UMS_EFC_ENH])
      |=> (st_r.ise[7:4] == $past(st_r.ise[7:4])))
    else $error("upper enables changed without enhanced bit");
  AST_THR_REEN: assert property (@(posedge pclk) disable iff (!presetn)
    (~thr_ready & ~st_r.thr_q) |=> ~st_r.thr_pend)
    else $error("transmit interrupt pending below threshold");

  // loopback routing and sleep enable
  AST_LOOP_CTS: assert property (@(posedge pclk) disable iff (!presetn)
    loop_en |-> (mls_val[UMS_MLS_CTS] == st_r.mlc[UMS_MLC_RTS])
      && (mls_val[UMS_MLS_DSR] == st_r.mlc[UMS_MLC_DTR]))
    else $error("loopback routing wrong");
  AST_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc & (paddr == UMS_OFF_ISE) & st_r.efc[UMS_EFC_ENH])
      |=> (sleep_en == $past(pwdata[UMS_ISE_SLEEP])))
    else $error("sleep output differs from written enable");

  // cover points for the main scenarios
  COV_MODEM_IRQ: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(irq_n) ##[1:12] rd_mls);
  COV_LOOP_CHANGE: cover property (@(posedge pclk) disable iff (!presetn)
    loop_en & ev[UMS_MLS_DCTS]);
  COV_READ_EVENT: cover property (@(posedge pclk) disable iff (!presetn)
    rd_mls & (ev != 4'h0));
  COV_ENH_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc & (paddr == UMS_OFF_ISE) & st_r.efc[UMS_EFC_ENH]);
  COV_RI_RISE: cover property (@(posedge pclk) disable iff (!presetn)
    modem_sel & ev[UMS_MLS_TERI]);
endmodule : ums_top

/* File: logic/ums_pkg.sv */
// shared constants and state layout for the modem status and interrupt enable block
package ums_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] UMS_OFF_MLS  = 8'h00; // modem_line_status, read only
  localparam logic [7:0] UMS_OFF_ISE  = 8'h04; // interrupt_source_enable
  localparam logic [7:0] UMS_OFF_EFC  = 8'h08; // enhanced_feature_control
  localparam logic [7:0] UMS_OFF_PFC  = 8'h0C; // pin_function_control
  localparam logic [7:0] UMS_OFF_MLC  = 8'h10; // modem_line_control
  localparam logic [7:0] UMS_OFF_PLS  = 8'h14; // pin_level_state, read only
  // modem_line_status field positions
  localparam int UMS_MLS_CD      = 7;
  localparam int UMS_MLS_RI      = 6;
  localparam int UMS_MLS_DSR     = 5;
  localparam int UMS_MLS_CTS     = 4;
  localparam int UMS_MLS_DCD     = 3;
  localparam int UMS_MLS_TERI    = 2;
  localparam int UMS_MLS_DDSR    = 1;
  localparam int UMS_MLS_DCTS    = 0;
  // interrupt_source_enable field positions
  localparam int UMS_ISE_CTS     = 7;
  localparam int UMS_ISE_RTS     = 6;
  localparam int UMS_ISE_XOFF    = 5;
  localparam int UMS_ISE_SLEEP   = 4;
  localparam int UMS_ISE_MODEM   = 3;
  localparam int UMS_ISE_RXLS    = 2;
  localparam int UMS_ISE_THR     = 1;
  localparam int UMS_ISE_RHR     = 0;
  // enhanced_feature_control write enable of the protected fields
  localparam int UMS_EFC_ENH     = 4;
  // pin_function_control modem pin select
  localparam int UMS_PFC_MODEM   = 1;
  // modem_line_control fields
  localparam int UMS_MLC_LOOP    = 4;
  localparam int UMS_MLC_RTS     = 1;
  localparam int UMS_MLC_DTR     = 0;
  // general pins that carry modem lines
  localparam int UMS_PIN_DSR     = 4;
  localparam int UMS_PIN_DTR     = 5;
  localparam int UMS_PIN_CD      = 6;
  localparam int UMS_PIN_RI      = 7;
  // masks of protected fields
  localparam logic [7:0] UMS_ISE_PROT = 8'hF0; // upper enables
  localparam logic [7:0] UMS_MLC_PROT = 8'hE4; // control bits 7..5 and bit 2
  localparam logic [7:0] UMS_PLS_HIDE = 8'hF0; // pins 4..7 read as zero while modem pins
  // reset values
  localparam logic [7:0] UMS_RST_BYTE = 8'h00;
  localparam logic [31:0] UMS_RST_WORD = 32'h0000_0000;
  // whole block state, one packed struct
  typedef struct packed {
    logic [7:0]  ise;       // interrupt_source_enable
    logic [7:0]  efc;       // enhanced_feature_control
    logic [7:0]  pfc;       // pin_function_control
    logic [7:0]  mlc;       // modem_line_control
    logic        cts_q;     // previous effective cts_n
    logic        dsr_q;     // previous effective dsr_n
    logic        ri_q;      // previous effective ri_n
    logic        cd_q;      // previous effective cd_n
    logic        rts_q;     // previous rts_n
    logic        thr_q;     // previous thr_ready
    logic [3:0]  delta;     // sticky change flags
    logic        thr_pend;  // transmit holding interrupt pending
    logic        xoff_pend; // xoff received pending
    logic        flow_pend; // cts/rts inactive edge pending
    logic        irq;       // registered interrupt request, active high
    logic [31:0] rdata;     // apb read data
  } ums_state_t;
endpackage : ums_pkg

/* File: logic/ums_sync.sv */
// two flip-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
module ums_sync #(
  parameter int WIDTH = 1  // number of synchronised bits
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // one two-stage chain per bit, reset to the inactive high level
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_r; // first stage, read only by the second
      logic hold_r; // second stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_r <= 1'b1;
          hold_r <= 1'b1;
        end
        else
        begin
          meta_r <= async_in[gi];
          hold_r <= meta_r;
        end
      end
      assign sync_out[gi] = hold_r;
    end
  endgenerate
endmodule : ums_sync

/* File: tb/ums_modem_model.sv */
// modem side model driving the active-low status lines and spare pins
`timescale 1ns/10ps
module ums_modem_model (
  input  wire logic       pclk,
  input  wire logic [3:0] want_n,  // wanted cts, dsr, cd, ri levels
  input  wire logic [3:0] spare,   // levels for general pins 0..3
  input  wire logic       slow,    // answer one cycle late
  input  wire logic       dtr_n,   // our own output seen on pin five
  output logic            cts_n,
  output logic      [7:0] pins
);
  logic [3:0] lag_r = 4'hF; // delayed copy for slow answers
  logic [3:0] now_r = 4'hF; // lines as driven, idle high
  logic [3:0] sp_r  = 4'h0; // spare pin levels
  // lines move only just after a clock edge, never mid-cycle
  always @(posedge pclk)
  begin
    lag_r <= want_n;
    now_r <= slow ? lag_r : want_n;
    sp_r  <= spare;
  end
  // pin map: ri on 7, cd on 6, dtr on 5, dsr on 4
  assign cts_n = now_r[0];
  assign pins  = {now_r[3], now_r[2], dtr_n, now_r[1], sp_r};
endmodule : ums_modem_model

/* File: tb/ums_top_tb.sv */
// self-checking bench for the modem status and interrupt enable block
`timescale 1ns/10ps
module ums_top_tb;
  import ums_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;         // clock, reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;                       // byte address
  logic [31:0] pwdata = 32'h0000_0000, prdata;      // bus data
  logic        pready, pslverr, rts_n, dtr_n, sleep_en, irq_n, cts_n;
  logic [7:0]  pins;                                // pin levels from model
  logic        rx_err_lvl = 1'b0, rhr_lvl = 1'b0, thr_ready = 1'b0;
  logic        xoff_pulse = 1'b0, xoff_ack = 1'b0, flow_ack = 1'b0;
  logic [3:0]  want_n = 4'hF, spare = 4'h0, lv, nv; // modem line levels
  logic        slow = 1'b0, erv;
  logic [31:0] rdv;                                 // last read word
  int          n_errors = 0, checked = 0, i;

  always #10 pclk = ~pclk;

  ums_top ums_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cts_n(cts_n), .general_pin_in(pins), .rts_n(rts_n), .dtr_n(dtr_n),
    .rx_err_lvl(rx_err_lvl), .rhr_lvl(rhr_lvl), .thr_ready(thr_ready),
    .xoff_pulse(xoff_pulse), .xoff_ack(xoff_ack), .flow_ack(flow_ack),
    .sleep_en(sleep_en), .irq_n(irq_n));

  ums_modem_model ums_modem_model_i (.pclk(pclk), .want_n(want_n), .spare(spare),
    .slow(slow), .dtr_n(dtr_n), .cts_n(cts_n), .pins(pins));

  // verdict and end of run, also reached on a hang
  task stop_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // bounded wait for the slave, no latency assumed
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      stop_test();
    end
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one-cycle acknowledge pulses
  task ack(input logic f, input logic x);
    flow_ack <= f;
    xoff_ack <= x;
    @(posedge pclk);
    flow_ack <= 1'b0;
    xoff_ack <= 1'b0;
    @(posedge pclk);
  endtask : ack

  // status word: levels inverted, cd/dsr/cts any change, ri rise only
  function automatic logic [7:0] exp_mls(input logic [3:0] o, input logic [3:0] n);
    return {~n[2], ~n[3], ~n[1], ~n[0], o[2] ^ n[2], ~o[3] & n[3], o[1] ^ n[1], o[0] ^ n[0]};
  endfunction : exp_mls

  initial
  begin
    void'($urandom(32'h4e93_c33b));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(UMS_OFF_ISE);
    chk(rdv, 32'h0000_0000);
    chk(32'({sleep_en, irq_n, rts_n, dtr_n}), 32'h0000_0007);
    // upper enables locked until the enhanced bit is set
    wr(UMS_OFF_ISE, 32'h0000_00FF);
    rd(UMS_OFF_ISE);
    chk(rdv, 32'h0000_000F);
    wr(UMS_OFF_ISE, 32'h0000_0000);
    wr(UMS_OFF_EFC, 32'h0000_0010);
    wr(UMS_OFF_ISE, 32'h0000_0010);
    cyc(2);
    chk(32'(sleep_en), 32'h0000_0001);
    wr(UMS_OFF_ISE, 32'h0000_0000);
    cyc(2);
    chk(32'(sleep_en), 32'h0000_0000);
    // random modem line changes with modem pins selected
    wr(UMS_OFF_PFC, 32'h0000_0002);
    lv = 4'hF;
    for (i = 0; i < 12; i++)
    begin
      nv = 4'($urandom());
      spare <= 4'($urandom());
      slow <= i[0];
      want_n <= nv;
      cyc(8);
      rd(UMS_OFF_MLS);
      chk(rdv, 32'(exp_mls(lv, nv)));
      rd(UMS_OFF_PLS);
      chk(rdv, 32'(spare));
      lv = nv;
    end
    // dsr change landing in the access cycle of a status read
    slow <= 1'b0;
    cyc(2);
    lv[1] = ~lv[1];
    want_n <= lv;
    cyc(2);
    rd(UMS_OFF_MLS);
    chk(rdv & 32'h0000_0002, 32'h0000_0000);
    rd(UMS_OFF_MLS);
    chk(rdv & 32'h0000_0002, 32'h0000_0002);
    ack(1'b1, 1'b0);
    // modem change interrupt, cleared by the status read
    wr(UMS_OFF_ISE, 32'h0000_0008);
    cyc(3);
    chk(32'(irq_n), 32'h0000_0001);
    lv[2] = ~lv[2];
    want_n <= lv;
    cyc(8);
    chk(32'(irq_n), 32'h0000_0000);
    rd(UMS_OFF_MLS);
    cyc(3);
    chk(32'(irq_n), 32'h0000_0001);
    // level sources: receive holding, then line error
    wr(UMS_OFF_ISE, 32'h0000_0000);
    for (i = 0; i < 2; i++)
    begin
      rhr_lvl <= (i == 0);
      rx_err_lvl <= (i == 1);
      cyc(3);
      chk(32'(irq_n), 32'h0000_0001);
      wr(UMS_OFF_ISE, (i == 0) ? 32'h0000_0001 : 32'h0000_0004);
      cyc(3);
      chk(32'(irq_n), 32'h0000_0000);
      wr(UMS_OFF_ISE, 32'h0000_0000);
    end
    rhr_lvl <= 1'b0;
    rx_err_lvl <= 1'b0;
    // transmit holding, then re-enable below threshold
    wr(UMS_OFF_ISE, 32'h0000_0002);
    thr_ready <= 1'b1;
    cyc(4);
    chk(32'(irq_n), 32'h0000_0000);
    thr_ready <= 1'b0;
    cyc(4);
    chk(32'(irq_n), 32'h0000_0001);
    wr(UMS_OFF_ISE, 32'h0000_0000);
    wr(UMS_OFF_ISE, 32'h0000_0002);
    cyc(4);
    chk(32'(irq_n), 32'h0000_0001);
    // xoff received
    wr(UMS_OFF_ISE, 32'h0000_0020);
    xoff_pulse <= 1'b1;
    @(posedge pclk);
    xoff_pulse <= 1'b0;
    cyc(4);
    chk(32'(irq_n), 32'h0000_0000);
    ack(1'b0, 1'b1);
    cyc(3);
    chk(32'(irq_n), 32'h0000_0001);
    // cts going inactive
    wr(UMS_OFF_ISE, 32'h0000_0080);
    lv[0] = 1'b0;
    want_n <= lv;
    cyc(8);
    ack(1'b1, 1'b0);
    cyc(3);
    chk(32'(irq_n), 32'h0000_0001);
    lv[0] = 1'b1;
    want_n <= lv;
    cyc(8);
    chk(32'(irq_n), 32'h0000_0000);
    // rts going inactive
    wr(UMS_OFF_ISE, 32'h0000_0040);
    wr(UMS_OFF_MLC, 32'h0000_0002);
    cyc(4);
    chk(32'(rts_n), 32'h0000_0000);
    ack(1'b1, 1'b0);
    wr(UMS_OFF_MLC, 32'h0000_0000);
    cyc(4);
    chk(32'(rts_n), 32'h0000_0001);
    chk(32'(irq_n), 32'h0000_0000);
    ack(1'b1, 1'b0);
    // loopback feeds rts and dtr into the status levels
    wr(UMS_OFF_ISE, 32'h0000_0000);
    wr(UMS_OFF_MLC, 32'h0000_0013);
    cyc(8);
    chk(32'({rts_n, dtr_n}), 32'h0000_0000);
    rd(UMS_OFF_MLS);
    chk(rdv & 32'h0000_0030, 32'h0000_0030);
    // unmapped read and write to the read-only status
    rd(8'h3C);
    chk(32'(erv), 32'h0000_0001);
    wr(UMS_OFF_MLS, 32'h0000_00FF);
    chk(32'(erv), 32'h0000_0001);
    stop_test();
  end
endmodule : ums_top_tb
